//--- radio_telegram_receive_buffer_test.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Self-checking bench for the telegram receive buffer
// ============================================================
module radio_telegram_receive_buffer_test;
  localparam int SLOTS = 2;
  logic       sys_clk, sys_rst, clk_en, reg_wr, reg_rd, tog;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [7:0] rx_byte;
  logic       rx_valid, new_telegram_flag;
  logic [7:0] exp_b [0:31];
  int         n_st, fails, n_tests, seed, k;

  rtb_receive_buffer #(.SLOT_CNT(SLOTS)) dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .new_telegram_flag(new_telegram_flag));
  rtb_radio_src src_u (
    .sys_clk(sys_clk), .rx_byte(rx_byte), .rx_valid(rx_valid));

  // 100 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ============================================================
  // Shared tasks
  // ============================================================
  // Compare and count; a mismatch is reported at once.
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Expected status byte; ack always follows the last request value.
  function automatic logic [7:0] st(input logic c, nw, ov, cs);
    return {1'b0, cs, 2'b00, ov, nw, c, tog};
  endfunction
  // Read data are sampled in the one cycle they stand.
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic stat_is(input logic c, nw, ov, cs);
    rd(rtb_pkg::ADDR_STATUS, d);
    chk(d, st(c, nw, ov, cs));
  endtask
  // Invert the request, then read status back to back; upper write
  // bits are random since only bit 0 carries meaning.
  task automatic tog_chk(input logic c, nw, ov, cs);
    logic [7:0] r;
    r = $random(seed);
    tog = ~tog;
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= rtb_pkg::ADDR_STATUS;
    reg_wdata <= {r[7:1], tog};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, st(c, nw, ov, cs));
  endtask
  // Check one 11-byte block of the image; bytes past the end read 0.
  task automatic show(input int blk);
    int i;
    for (i = 0; i < 11; i++) begin
      rd(rtb_pkg::ADDR_DATA0 + 4'(i), d);
      chk(d, (blk * 11 + i < n_st) ? exp_b[blk * 11 + i] : 8'h00);
    end
  endtask
  // Junk, sync pair, header, body, checksum; body stays below 0x80 so
  // it can never mimic a sync pair.
  task automatic send_tel(input logic [2:0] seq, input int len, bit bad);
    logic [7:0] s;
    int i;
    s = 8'h00;
    n_st = len;
    exp_b[0] = {seq, len[4:0]};
    for (i = 1; i < len; i++)
      exp_b[i] = $random(seed) & 8'h7F;
    for (i = 0; i < len; i++)
      s = s + exp_b[i];
    src_u.send_byte($random(seed) & 8'h7F);
    src_u.send_byte(rtb_pkg::FIRST_SYNC_BYTE);
    src_u.send_byte(rtb_pkg::SECOND_SYNC_BYTE);
    for (i = 0; i < len; i++)
      src_u.send_byte(exp_b[i]);
    src_u.send_byte(bad ? ~s : s);
    src_u.go_idle();
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    tally_and_finish();
  end

  // ============================================================
  // Main sequence
  // ============================================================
  initial begin
    seed = 40564;
    fails = 0;
    n_tests = 0;
    tog = 1'b0;
    clk_en = 1'b1;
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    stat_is(0, 0, 0, 0);
    rd(4'hF, d);
    chk(d, 8'h00);
    for (k = 0; k < 3; k++) begin
      send_tel(k[2:0], 11, 0);
      #1 chk({7'h00, new_telegram_flag}, 8'h01);
      rd(rtb_pkg::ADDR_LAST_HDR, d);
      chk(d, exp_b[0]);
      tog_chk(0, 0, 0, 0);
      wr(rtb_pkg::ADDR_DATA0, ~exp_b[0]);
      show(0);
    end
    $display("standard telegrams done");
    send_tel(3'h1, 23, 0);
    tog_chk(0, 0, 0, 0);
    show(0);
    tog_chk(1, 0, 0, 0);
    show(1);
    tog_chk(1, 0, 0, 0);
    show(2);
    $display("long telegram done");
    send_tel(3'h0, 11, 1);
    stat_is(1, 0, 0, 1);
    tog_chk(0, 0, 0, 0);
    rd(rtb_pkg::ADDR_DATA0, d);
    chk(d, exp_b[22]);
    $display("bad checksum done");
    for (k = 0; k <= SLOTS; k++)
      send_tel(k[2:0], 11, 0);
    stat_is(0, 1, 1, 1);
    for (k = 0; k < SLOTS; k++) begin
      tog_chk(0, k < SLOTS - 1, 0, 0);
      rd(rtb_pkg::ADDR_DATA0, d);
      chk(d, {k[2:0], rtb_pkg::STD_LEN});
    end
    $display("overflow done");
    // Frozen clock enable: a toggle write must leave the ack untouched.
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(rtb_pkg::ADDR_STATUS, {7'h00, ~tog});
    clk_en <= 1'b1;
    stat_is(0, 0, 0, 0);
    $display("clock enable done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- rtb_pkg.sv
`default_nettype none

package rtb_pkg;

  // ==========================================================================
  // Telegram framing
  // ==========================================================================
  localparam logic [7:0] FIRST_SYNC_BYTE  = 8'hA5;
  localparam logic [7:0] SECOND_SYNC_BYTE = 8'h5A;
  localparam int         SEQ_MSB          = 7;
  localparam int         SEQ_LSB          = 5;
  localparam int         LEN_MSB          = 4;
  localparam int         LEN_LSB          = 0;
  localparam logic [4:0] STD_LEN          = 5'h0B;
  localparam logic [2:0] SEQ_UNKNOWN      = 3'h0;
  localparam logic [2:0] SEQ_KNOWN        = 3'h1;
  localparam logic [2:0] SEQ_LEARNT       = 3'h2;
  localparam int         SLOT_BYTES       = 32;
  localparam int         IMG_BYTES        = 11;

  // ==========================================================================
  // Register port map and status bit positions
  // ==========================================================================
  localparam int         ADDR_W           = 4;
  localparam logic [3:0] ADDR_STATUS      = 4'h0;
  localparam logic [3:0] ADDR_DATA0       = 4'h1;
  localparam logic [3:0] ADDR_DATA_LAST   = 4'hB;
  localparam logic [3:0] ADDR_LAST_HDR    = 4'hC;
  localparam int         BIT_ACK          = 0;
  localparam int         BIT_CONT         = 1;
  localparam int         BIT_NEW          = 2;
  localparam int         BIT_OVF          = 3;
  localparam int         BIT_CSUM         = 6;
  localparam int         BIT_REQ          = 0;
  localparam logic [7:0] STATUS_RESET     = 8'h00;
  localparam logic [7:0] DATA_RESET       = 8'h00;

  // ==========================================================================
  // Receive parser states
  // ==========================================================================
  typedef enum logic [2:0] {
    RTB_HUNT,
    RTB_SYNC2,
    RTB_HEADER,
    RTB_BODY,
    RTB_CHECK
  } rtb_state_t;

endpackage

`default_nettype wire

//--- rtb_radio_src.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Radio receiver model feeding the byte stream
// ============================================================
module rtb_radio_src (
  input  wire logic       sys_clk,
  output var  logic [7:0] rx_byte,
  output var  logic       rx_valid
);
  // Quiet line at time zero.
  initial begin
    rx_byte  = 8'h00;
    rx_valid = 1'b0;
  end
  // One byte per cycle, launched just after an edge and held one cycle.
  task automatic send_byte(input logic [7:0] b);
    @(posedge sys_clk);
    rx_byte  <= b;
    rx_valid <= 1'b1;
  endtask
  // The byte inverts on release so a stale value never looks like data.
  task automatic go_idle();
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_byte  <= ~rx_byte;
  endtask
endmodule
`default_nettype wire

//--- rtb_receive_buffer.sv
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module rtb_receive_buffer #(
  parameter int SLOT_CNT = 4
) (
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      clk_en,
  input  wire logic [7:0]                rx_byte,
  input  wire logic                      rx_valid,
  input  wire logic [rtb_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output var  logic [7:0]                reg_rdata,
  output var  logic                      new_telegram_flag
);

  localparam int PTR_W = (SLOT_CNT > 1) ? $clog2(SLOT_CNT) : 1;

  // ==========================================================================
  // Storage
  // ==========================================================================
  // Each slot holds one whole telegram from header to last body byte, so a
  // slot is freed only after its last block has been shown.
  logic [7:0]          mem_r [SLOT_CNT][rtb_pkg::SLOT_BYTES];
  logic [5:0]          len_r [SLOT_CNT];
  logic [PTR_W-1:0]    wr_ptr_r;
  logic [PTR_W-1:0]    rd_ptr_r;
  logic [PTR_W:0]      count_r;

  // Parser state.
  rtb_pkg::rtb_state_t state_r;
  logic [4:0]          body_left_r;
  logic [5:0]          wr_idx_r;
  logic [7:0]          sum_r;
  logic                drop_r;
  logic                commit;
  logic                bad_frame;
  logic                ovf_event;
  logic                slot_full;

  // Presentation state.
  logic                req_bit_r;
  logic                ack_r;
  logic                cont_r;
  logic                cont_pend_r;
  logic [1:0]          blk_r;
  logic                ovf_r;
  logic                csum_r;
  logic [7:0]          img_r [rtb_pkg::IMG_BYTES];
  logic [7:0]          last_hdr_r;
  logic                req_event;
  logic                pop;
  logic [7:0]          status_byte;

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  // Byte offset of a display block inside a stored telegram.
  function automatic logic [5:0] blk_off(input logic [1:0] blk);
    logic [5:0] off;
    off = 6'(blk) * 6'(rtb_pkg::IMG_BYTES);
    return off;
  endfunction

  // True when the given block is the final one of a telegram of that length.
  function automatic logic is_last(input logic [1:0] blk,
                                   input logic [5:0] len);
    logic [6:0] end_pos;
    end_pos = 7'(blk_off(blk)) + 7'(rtb_pkg::IMG_BYTES);
    return end_pos >= 7'(len);
  endfunction

  // Reads one stored byte; positions past the telegram end show zero.
  function automatic logic [7:0] byte_at(input logic [PTR_W-1:0] slot,
                                         input logic [6:0]       pos);
    logic [7:0] val;
    val = rtb_pkg::DATA_RESET;
    if (pos < 7'(len_r[slot])) begin
      val = mem_r[slot][pos[4:0]];
    end
    return val;
  endfunction

  // ==========================================================================
  // Receive parser
  // ==========================================================================
  // The frame is judged only at its checksum byte; a frame that started
  // while every slot was full is marked for dropping from its header on.
  assign commit    = clk_en && rx_valid && (state_r == rtb_pkg::RTB_CHECK) &&
                     (rx_byte == sum_r) && !drop_r;
  assign bad_frame = clk_en && rx_valid && (state_r == rtb_pkg::RTB_CHECK) &&
                     ((rx_byte != sum_r) || drop_r);
  assign ovf_event = bad_frame && drop_r;
  assign slot_full = (count_r == (PTR_W+1)'(SLOT_CNT));

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r     <= rtb_pkg::RTB_HUNT;
      body_left_r <= 5'h00;
      wr_idx_r    <= 6'h00;
      sum_r       <= 8'h00;
      drop_r      <= 1'b0;
    end else if (clk_en && rx_valid) begin
      case (state_r)
        rtb_pkg::RTB_HUNT: begin
          if (rx_byte == rtb_pkg::FIRST_SYNC_BYTE) begin
            state_r <= rtb_pkg::RTB_SYNC2;
          end
        end
        rtb_pkg::RTB_SYNC2: begin
          // A repeated first sync byte keeps the hunt aligned.
          if (rx_byte == rtb_pkg::SECOND_SYNC_BYTE) begin
            state_r <= rtb_pkg::RTB_HEADER;
          end else if (rx_byte != rtb_pkg::FIRST_SYNC_BYTE) begin
            state_r <= rtb_pkg::RTB_HUNT;
          end
        end
        rtb_pkg::RTB_HEADER: begin
          // The sync bytes never reach the sum or the memory.
          sum_r    <= rx_byte;
          wr_idx_r <= 6'h01;
          drop_r   <= slot_full;
          // Length includes the header, so one byte less is body.
          if (rx_byte[rtb_pkg::LEN_MSB:rtb_pkg::LEN_LSB] <= 5'h01) begin
            body_left_r <= 5'h00;
            state_r     <= rtb_pkg::RTB_CHECK;
          end else begin
            body_left_r <= rx_byte[rtb_pkg::LEN_MSB:rtb_pkg::LEN_LSB] - 5'h01;
            state_r     <= rtb_pkg::RTB_BODY;
          end
        end
        rtb_pkg::RTB_BODY: begin
          sum_r       <= sum_r + rx_byte;
          wr_idx_r    <= wr_idx_r + 6'h01;
          body_left_r <= body_left_r - 5'h01;
          if (body_left_r == 5'h01) begin
            state_r <= rtb_pkg::RTB_CHECK;
          end
        end
        rtb_pkg::RTB_CHECK: begin
          // The checksum byte itself is consumed here and never stored.
          state_r <= rtb_pkg::RTB_HUNT;
        end
        default: begin
          state_r <= rtb_pkg::RTB_HUNT;
        end
      endcase
    end
  end

  // Bytes land in the write slot in arrival order; the slot only becomes
  // visible when the frame commits, so a bad frame simply leaves garbage
  // behind in an unowned slot. The header edge tests the queue directly,
  // since drop_r still holds the previous frame's verdict there and a full
  // queue must never see its oldest slot overwritten.
  always_ff @(posedge sys_clk) begin
    if (clk_en && rx_valid) begin
      if (state_r == rtb_pkg::RTB_HEADER && !slot_full) begin
        mem_r[wr_ptr_r][0] <= rx_byte;
      end else if (state_r == rtb_pkg::RTB_BODY && !drop_r) begin
        mem_r[wr_ptr_r][wr_idx_r[4:0]] <= rx_byte;
      end
    end
  end

  // Stored length is header plus body, the count the display blocks use.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < SLOT_CNT; i++) begin
        len_r[i] <= 6'h00;
      end
    end else if (commit) begin
      len_r[wr_ptr_r] <= wr_idx_r;
    end
  end

  // Last accepted header, kept so software can see the sequence code.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_hdr_r <= rtb_pkg::DATA_RESET;
    end else if (commit) begin
      last_hdr_r <= mem_r[wr_ptr_r][0];
    end
  end

  // ==========================================================================
  // Slot queue
  // ==========================================================================
  // Only good frames advance the write pointer; a bad one is lost.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (commit) begin
        wr_ptr_r <= PTR_W'(wr_ptr_r + 1'b1);
      end
      if (pop) begin
        rd_ptr_r <= PTR_W'(rd_ptr_r + 1'b1);
      end
      if (commit && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !commit) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  // A telegram still being shown in blocks no longer counts as new.
  assign new_telegram_flag = (count_r > (PTR_W+1)'(cont_pend_r));

  // ==========================================================================
  // Read handshake
  // ==========================================================================
  // Any write to the control byte with clk_en high that flips the request bit is a request,
  // so both directions of the toggle are honoured alike.
  assign req_event = clk_en && reg_wr && (reg_addr == rtb_pkg::ADDR_STATUS) &&
                     (reg_wdata[rtb_pkg::BIT_REQ] != req_bit_r);

  assign pop = req_event && (count_r != '0) &&
               (cont_pend_r ? is_last(blk_r + 2'h1, len_r[rd_ptr_r])
                            : is_last(2'h0, len_r[rd_ptr_r]));

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_bit_r <= 1'b0;
    end else if (req_event) begin
      req_bit_r <= reg_wdata[rtb_pkg::BIT_REQ];
    end
  end

  // Present the next block and acknowledge in the same edge, so the ack
  // never runs ahead of the data it vouches for.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_r       <= 1'b0;
      cont_r      <= 1'b0;
      cont_pend_r <= 1'b0;
      blk_r       <= 2'h0;
      for (int i = 0; i < rtb_pkg::IMG_BYTES; i++) begin
        img_r[i] <= rtb_pkg::DATA_RESET;
      end
    end else if (req_event) begin
      ack_r <= reg_wdata[rtb_pkg::BIT_REQ];
      if (cont_pend_r) begin
        blk_r       <= blk_r + 2'h1;
        cont_r      <= 1'b1;
        cont_pend_r <= !pop;
        for (int i = 0; i < rtb_pkg::IMG_BYTES; i++) begin
          img_r[i] <= byte_at(rd_ptr_r,
                              7'(blk_off(blk_r + 2'h1)) + 7'(i));
        end
      end else if (count_r != '0) begin
        blk_r       <= 2'h0;
        cont_r      <= 1'b0;
        cont_pend_r <= !pop;
        for (int i = 0; i < rtb_pkg::IMG_BYTES; i++) begin
          img_r[i] <= byte_at(rd_ptr_r, 7'(i));
        end
      end else begin
        // Nothing stored: the old image stays, the ack moves and cont clears.
        cont_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Error flags
  // ==========================================================================
  // Both flags stay until the next request; a new error in that same cycle
  // wins over the clear so it is never missed.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      csum_r <= 1'b0;
    end else if (bad_frame) begin
      csum_r <= 1'b1;
    end else if (req_event) begin
      csum_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovf_r <= 1'b0;
    end else if (ovf_event) begin
      ovf_r <= 1'b1;
    end else if (req_event) begin
      ovf_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Register read port
  // ==========================================================================
  always_comb begin
    status_byte                   = rtb_pkg::STATUS_RESET;
    status_byte[rtb_pkg::BIT_ACK]  = ack_r;
    status_byte[rtb_pkg::BIT_CONT] = cont_r;
    status_byte[rtb_pkg::BIT_NEW]  = new_telegram_flag;
    status_byte[rtb_pkg::BIT_OVF]  = ovf_r;
    status_byte[rtb_pkg::BIT_CSUM] = csum_r;
  end

  // Read data stand only in the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        if (reg_addr == rtb_pkg::ADDR_STATUS) begin
          reg_rdata <= status_byte;
        end else if (reg_addr >= rtb_pkg::ADDR_DATA0 &&
                     reg_addr <= rtb_pkg::ADDR_DATA_LAST) begin
          reg_rdata <= img_r[reg_addr - rtb_pkg::ADDR_DATA0];
        end else if (reg_addr == rtb_pkg::ADDR_LAST_HDR) begin
          reg_rdata <= last_hdr_r;
        end
      end
    end
  end

endmodule

`default_nettype wire

//--- rtb_receive_buffer_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Port checker for the telegram receive buffer
// ============================================================
module rtb_receive_buffer_asserts #(
  parameter int SLOT_CNT = 4
) (
  input wire logic                        sys_clk,
  input wire logic                        sys_rst,
  input wire logic                        clk_en,
  input wire logic [7:0]                  rx_byte,
  input wire logic                        rx_valid,
  input wire logic [rtb_pkg::ADDR_W-1:0]  reg_addr,
  input wire logic [7:0]                  reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [7:0]                  reg_rdata,
  input wire logic                        new_telegram_flag
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  // A status read always reports the port flag it mirrors.
  AST_NEW_BIT: assert property (
    reg_rd && reg_addr == rtb_pkg::ADDR_STATUS
    |=> reg_rdata[rtb_pkg::BIT_NEW] == $past(new_telegram_flag))
    else $error("status new bit differs from flag port");
  // The flag only rises after a byte was taken; it is already high when the last
  // block of a long telegram is shown while others wait behind it.
  AST_NEW_RISE: assert property (
    $rose(new_telegram_flag) |-> $past(rx_valid) || $past(reg_wr))
    else $error("new flag rose without a received byte");
  // The flag only falls after a request write.
  AST_NEW_FALL: assert property (
    $fell(new_telegram_flag) |-> $past(reg_wr))
    else $error("new flag fell without a request");
  // With no byte and no request the flag cannot move.
  AST_NEW_QUIET: assert property (
    !rx_valid && !reg_wr |=> $stable(new_telegram_flag))
    else $error("new flag moved with idle inputs");
  // A request write followed at once by a status read shows the copy.
  AST_ACK_COPY: assert property (
    (reg_wr && reg_addr == rtb_pkg::ADDR_STATUS)
    ##1 (reg_rd && reg_addr == rtb_pkg::ADDR_STATUS)
    |=> reg_rdata[rtb_pkg::BIT_ACK] == $past(reg_wdata[0], 2))
    else $error("ack bit does not copy the request bit");
  // Read data stand for one cycle only.
  AST_RDATA_IDLE: assert property (
    clk_en && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data present without a read");
  // Unused status bits stay clear.
  AST_STATUS_SPARE: assert property (
    reg_rd && reg_addr == rtb_pkg::ADDR_STATUS
    |=> reg_rdata[7] == 1'b0 && reg_rdata[5:4] == 2'b00)
    else $error("spare status bits set");
  // Addresses past the map read as zero.
  AST_UNMAPPED: assert property (
    reg_rd && reg_addr > rtb_pkg::ADDR_LAST_HDR |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");

  // Main scenarios reached.
  COV_NEW: cover property ($rose(new_telegram_flag));
  COV_CONT: cover property (reg_rdata[rtb_pkg::BIT_CONT]);
  COV_OVF: cover property (reg_rdata[rtb_pkg::BIT_OVF]);
  COV_CSUM: cover property (reg_rdata[rtb_pkg::BIT_CSUM]);
endmodule

bind rtb_receive_buffer rtb_receive_buffer_asserts #(
  .SLOT_CNT(SLOT_CNT)
) chk_u (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .rx_byte(rx_byte), .rx_valid(rx_valid), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .new_telegram_flag(new_telegram_flag)
);
`default_nettype wire
